/* ocsr_regs.sv */
`timescale 1ns/1ps
module ocsr_regs (
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    input  wire ocsr_pkg::ocsr_bus_req_t bus_i,
    output logic [31:0]                 rdata_o,
    input  wire logic                   eeprom_detect_i,
    output logic                        eeprom_present_flag_o,
    output ocsr_pkg::ocsr_rom_req_t     rom_req_o,
    input  wire logic                   rom_ack_i,
    input  wire logic [7:0]             rom_data_i,
    output logic [3:0]                  phys_response_retry_max_o,
    output logic [3:0]                  at_response_retry_max_o,
    output logic [3:0]                  at_request_retry_max_o,
    output logic [31:0]                 bus_manager_id_o,
    output logic [31:0]                 bandwidth_available_o,
    output logic [31:0]                 channels_available_hi_o,
    output logic [31:0]                 channels_available_lo_o
);
    ocsr_pkg::ocsr_rom_state_t state_reg, state_next;
    logic        started_reg;
    logic        ptr_load_reg;
    logic        rom_addr_clear_reg;
    logic        rom_byte_read_go_reg;
    logic [7:0]  rom_addr_reg;
    logic [7:0]  rom_byte_value_reg;
    logic [7:0]  option_rom_pointer_reg;
    logic        eeprom_present_reg;
    logic [11:0] retry_reg;
    logic [31:0] cswap_data_reg;
    logic [31:0] cswap_cmp_reg;
    logic        compare_swap_done_reg;
    logic [1:0]  csr_resource_select_reg;
    logic [31:0] csr_res_reg [4];
    logic [31:0] rdata_next;

    wire wr_access  = bus_i.wr && bus_i.addr == ocsr_pkg::ADDR_EEPROM_ACCESS;
    wire wr_retry   = bus_i.wr && bus_i.addr == ocsr_pkg::ADDR_RETRY_LIMITS;
    wire wr_control = bus_i.wr && bus_i.addr == ocsr_pkg::ADDR_CSWAP_CONTROL;
    wire wr_data_ld = bus_i.wr && bus_i.addr == ocsr_pkg::ADDR_CSWAP_DATA_LD;
    wire wr_cmp_ld  = bus_i.wr && bus_i.addr == ocsr_pkg::ADDR_CSWAP_CMP_LD;
    wire go_set     = wr_access && bus_i.wdata[ocsr_pkg::BIT_READ_GO];
    wire clr_set    = wr_access && bus_i.wdata[ocsr_pkg::BIT_ADDR_CLEAR];
    wire rom_done   = state_reg == ocsr_pkg::OCSR_ROM_WAIT && rom_ack_i;
    wire byte_done  = rom_done && !ptr_load_reg;
    wire ptr_done   = rom_done && ptr_load_reg;
    // Pointer fetch runs once after reset when an EEPROM is detected, ahead of any software read
    wire ptr_start  = eeprom_present_reg && !started_reg;
    wire byte_start = rom_byte_read_go_reg && !rom_addr_clear_reg && started_reg;
    wire [31:0] sel_value = csr_res_reg[bus_i.wdata[1:0]];
    wire        swap_hit  = sel_value == cswap_cmp_reg;

    wire [31:0] access_word  = {rom_addr_clear_reg, 5'h00, rom_byte_read_go_reg, 1'b0,
                                rom_byte_value_reg, 8'h00, option_rom_pointer_reg};
    wire [31:0] retry_word   = {16'h0000, 4'h0, retry_reg};
    wire [31:0] control_word = {compare_swap_done_reg, 29'h00000000, csr_resource_select_reg};

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ocsr_pkg::OCSR_ROM_IDLE: begin
                if ((ptr_start && !started_reg) || byte_start) begin
                    state_next = ocsr_pkg::OCSR_ROM_WAIT;
                end
            end
            ocsr_pkg::OCSR_ROM_WAIT: begin
                if (rom_ack_i) begin
                    state_next = ocsr_pkg::OCSR_ROM_IDLE;
                end
            end
            default: state_next = ocsr_pkg::OCSR_ROM_IDLE;
        endcase
    end

    assign rom_req_o.req  = state_reg == ocsr_pkg::OCSR_ROM_WAIT;
    assign rom_req_o.addr = ptr_load_reg ? ocsr_pkg::OPTION_ROM_WORD_OFFSET : rom_addr_reg;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg <= ocsr_pkg::OCSR_ROM_IDLE;
            started_reg <= 1'b0;
            ptr_load_reg <= 1'b0;
            eeprom_present_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            // Strap sampled clocked, after reset release
            if (!started_reg && eeprom_detect_i) begin
                eeprom_present_reg <= 1'b1;
            end
            if (ptr_start) begin
                started_reg <= 1'b1;
                ptr_load_reg <= 1'b1;
            end else if (!eeprom_present_reg && !eeprom_detect_i) begin
                started_reg <= 1'b1;
            end
            if (ptr_done) begin
                ptr_load_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rom_addr_clear_reg <= 1'b0;
            rom_byte_read_go_reg <= 1'b0;
            rom_addr_reg <= 8'h00;
            rom_byte_value_reg <= 8'h00;
            option_rom_pointer_reg <= ocsr_pkg::OPTION_ROM_NONE;
        end else begin
            // Clear takes a cycle; the bit reads one until zeroing is done
            rom_addr_clear_reg <= clr_set;
            if (rom_addr_clear_reg) begin
                rom_addr_reg <= 8'h00;
            end else if (byte_done) begin
                rom_addr_reg <= rom_addr_reg + 8'h01;
            end
            if (go_set) begin
                rom_byte_read_go_reg <= 1'b1;
            end else if (byte_done) begin
                rom_byte_read_go_reg <= 1'b0;
            end
            if (byte_done) begin
                rom_byte_value_reg <= rom_data_i;
            end
            if (ptr_done) begin
                option_rom_pointer_reg <= rom_data_i;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            retry_reg <= {ocsr_pkg::RETRY_RESET, ocsr_pkg::RETRY_RESET,
                          ocsr_pkg::RETRY_RESET};
        end else if (wr_retry) begin
            retry_reg <= bus_i.wdata[11:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cswap_data_reg <= 32'h00000000;
            cswap_cmp_reg <= 32'h00000000;
            compare_swap_done_reg <= 1'b1;
            csr_resource_select_reg <= ocsr_pkg::CSR_SEL_RESET;
            for (int i = 0; i < 4; i++) begin
                csr_res_reg[i] <= 32'h00000000;
            end
        end else begin
            if (wr_data_ld) begin
                cswap_data_reg <= bus_i.wdata;
            end
            if (wr_cmp_ld) begin
                cswap_cmp_reg <= bus_i.wdata;
            end
            // Swap is single-cycle, so done drops on the write and returns next cycle
            compare_swap_done_reg <= !wr_control;
            if (wr_control) begin
                csr_resource_select_reg <= bus_i.wdata[1:0];
                if (swap_hit) begin
                    csr_res_reg[bus_i.wdata[1:0]] <= cswap_data_reg;
                end
            end
        end
    end

    always_comb begin
        case (bus_i.addr)
            ocsr_pkg::ADDR_EEPROM_ACCESS: rdata_next = access_word;
            ocsr_pkg::ADDR_RETRY_LIMITS:  rdata_next = retry_word;
            ocsr_pkg::ADDR_CSWAP_DATA:    rdata_next = cswap_data_reg;
            ocsr_pkg::ADDR_CSWAP_COMPARE: rdata_next = cswap_cmp_reg;
            ocsr_pkg::ADDR_CSWAP_CONTROL: rdata_next = control_word;
            default:                      rdata_next = 32'h00000000;
        endcase
    end

    logic [31:0] rdata_reg;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= bus_i.rd ? rdata_next : 32'h00000000;
        end
    end
    assign rdata_o = rdata_reg;

    assign eeprom_present_flag_o     = eeprom_present_reg;
    assign phys_response_retry_max_o = retry_reg[11:8];
    assign at_response_retry_max_o   = retry_reg[7:4];
    assign at_request_retry_max_o    = retry_reg[3:0];
    assign bus_manager_id_o          = csr_res_reg[0];
    assign bandwidth_available_o     = csr_res_reg[1];
    assign channels_available_hi_o   = csr_res_reg[2];
    assign channels_available_lo_o   = csr_res_reg[3];
endmodule // ocsr_regs

/* ocsr_pkg.sv */
package ocsr_pkg;
    localparam logic [7:0] ADDR_EEPROM_ACCESS  = 8'h04;
    localparam logic [7:0] ADDR_RETRY_LIMITS   = 8'h08;
    localparam logic [7:0] ADDR_CSWAP_DATA     = 8'h0c;
    localparam logic [7:0] ADDR_CSWAP_COMPARE  = 8'h10;
    localparam logic [7:0] ADDR_CSWAP_CONTROL  = 8'h14;
    // Operand registers are read-only in the map; software loads them here
    localparam logic [7:0] ADDR_CSWAP_DATA_LD  = 8'h40;
    localparam logic [7:0] ADDR_CSWAP_CMP_LD   = 8'h44;

    localparam int BIT_ADDR_CLEAR   = 31;
    localparam int BIT_READ_GO      = 25;
    localparam int BIT_CSWAP_DONE   = 31;
    localparam int POS_ROM_VALUE    = 16;
    localparam int POS_PHYS_RETRY   = 8;
    localparam int POS_AT_RESP      = 4;
    localparam int POS_AT_REQ       = 0;

    localparam logic [7:0] OPTION_ROM_WORD_OFFSET = 8'h28;
    localparam logic [7:0] OPTION_ROM_NONE        = 8'h00;
    localparam logic [3:0] RETRY_RESET            = 4'h0;
    localparam logic [1:0] CSR_SEL_RESET          = 2'h0;

    typedef enum logic [1:0] {
        OCSR_BUS_MANAGER_ID      = 2'h0,
        OCSR_BANDWIDTH_AVAILABLE = 2'h1,
        OCSR_CHANNELS_AVAIL_HI   = 2'h2,
        OCSR_CHANNELS_AVAIL_LO   = 2'h3
    } ocsr_resource_t;

    typedef enum logic [1:0] {
        OCSR_ROM_IDLE = 2'b00,
        OCSR_ROM_WAIT = 2'b01
    } ocsr_rom_state_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ocsr_bus_req_t;

    typedef struct packed {
        logic       req;
        logic [7:0] addr;
    } ocsr_rom_req_t;
endpackage

/* ocsr_regs_monitor.sv */
`timescale 1ns/1ps
module ocsr_regs_monitor (
    input wire logic                    clock_i,
    input wire logic                    rst_n_i,
    input wire ocsr_pkg::ocsr_bus_req_t bus_i,
    input wire logic [31:0]             rdata_o,
    input wire logic                    eeprom_present_flag_o,
    input wire ocsr_pkg::ocsr_rom_req_t rom_req_o,
    input wire logic                    rom_ack_i,
    input wire logic [3:0]              phys_response_retry_max_o,
    input wire logic [3:0]              at_response_retry_max_o,
    input wire logic [3:0]              at_request_retry_max_o,
    input wire logic [31:0]             bus_manager_id_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    wire        wr_retry = bus_i.wr && bus_i.addr == ocsr_pkg::ADDR_RETRY_LIMITS;
    wire        wr_ctrl  = bus_i.wr && bus_i.addr == ocsr_pkg::ADDR_CSWAP_CONTROL;
    wire [11:0] retry    = {phys_response_retry_max_o, at_response_retry_max_o,
                            at_request_retry_max_o};
    rom_rsvd_a: assert property (
        $past(bus_i.rd) && $past(bus_i.addr) == ocsr_pkg::ADDR_EEPROM_ACCESS
        |-> rdata_o[30:26] == 5'h0 && !rdata_o[24] && rdata_o[15:8] == 8'h0)
        else $error("reserved access bits not zero");
    retry_rsvd_a: assert property (
        $past(bus_i.rd) && $past(bus_i.addr) == ocsr_pkg::ADDR_RETRY_LIMITS
        |-> rdata_o[31:12] == 20'h0) else $error("retry upper bits not zero");
    ctrl_rsvd_a: assert property (
        $past(bus_i.rd) && $past(bus_i.addr) == ocsr_pkg::ADDR_CSWAP_CONTROL
        |-> rdata_o[30:2] == 29'h0) else $error("control reserved bits not zero");
    retry_load_a: assert property (wr_retry |=> retry == $past(bus_i.wdata[11:0]))
        else $error("retry limits not loaded");
    retry_hold_a: assert property (!wr_retry |=> $stable(retry))
        else $error("retry limits changed without a write");
    // A fetch must not move or vanish before the engine answers it
    req_hold_a: assert property (
        rom_req_o.req && !rom_ack_i |=> rom_req_o.req && $stable(rom_req_o.addr))
        else $error("byte fetch dropped before answer");
    no_eeprom_a: assert property (!eeprom_present_flag_o |-> !rom_req_o.req)
        else $error("fetch without a detected EEPROM");
    swap_other_a: assert property (
        wr_ctrl && bus_i.wdata[1:0] != 2'h0 |=> $stable(bus_manager_id_o))
        else $error("unselected resource changed");
    cover property (wr_ctrl ##1 !wr_ctrl);
    cover property (rom_req_o.req ##1 rom_ack_i);
    cover property (wr_retry);
endmodule // ocsr_regs_monitor

/* ocsr_eeprom_model.sv */
`timescale 1ns/1ps
module ocsr_eeprom_model #(parameter logic [7:0] PTR = 8'h4c) (
    input  wire logic                    clock_i,
    input  wire ocsr_pkg::ocsr_rom_req_t req_i,
    input  wire logic [2:0]              delay_i,
    output logic                         ack_o,
    output logic [7:0]                   data_o
);
    logic [2:0] cnt_reg = 3'h0;
    initial ack_o = 1'b0;
    initial data_o = 8'h0;
    always @(posedge clock_i) begin
        if (ack_o) begin
            ack_o <= 1'b0;
            data_o <= ~data_o; // Byte no longer valid, so never leave it standing
            cnt_reg <= 3'h0;
        end else if (req_i.req && cnt_reg >= delay_i) begin
            ack_o <= 1'b1;
            data_o <= (req_i.addr == 8'h28) ? PTR : req_i.addr ^ 8'h5a;
        end else begin
            cnt_reg <= req_i.req ? cnt_reg + 3'h1 : 3'h0;
        end
    end
endmodule // ocsr_eeprom_model

/* ocsr_regs_bench.sv */
`timescale 1ns/1ps
module ocsr_regs_bench;
    localparam logic [7:0] PTR = 8'h4c;
    localparam logic [7:0] A_ROM = ocsr_pkg::ADDR_EEPROM_ACCESS;
    localparam logic [7:0] A_CTL = ocsr_pkg::ADDR_CSWAP_CONTROL;
    logic clock_i, rst_n_i, detect, ack, pres;
    logic [7:0] rom_d;
    logic [2:0] delay = 3'h0;
    logic [3:0] ph_o, rs_o, rq_o;
    logic [31:0] rdata_o, g, d, c, res[4];
    logic [3:0][31:0] res_o;
    ocsr_pkg::ocsr_bus_req_t bus_i;
    ocsr_pkg::ocsr_rom_req_t rom_req;
    int fails = 0, checks = 0, s;
    ocsr_regs dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .eeprom_detect_i(detect), .eeprom_present_flag_o(pres), .rom_req_o(rom_req),
        .rom_ack_i(ack), .rom_data_i(rom_d), .phys_response_retry_max_o(ph_o),
        .at_response_retry_max_o(rs_o), .at_request_retry_max_o(rq_o),
        .bus_manager_id_o(res_o[0]), .bandwidth_available_o(res_o[1]),
        .channels_available_hi_o(res_o[2]), .channels_available_lo_o(res_o[3]));
    ocsr_eeprom_model #(.PTR(PTR)) rom (.clock_i(clock_i), .req_i(rom_req),
        .delay_i(delay), .ack_o(ack), .data_o(rom_d));
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [7:0] a, input logic [31:0] v, input logic w);
        @(posedge clock_i);
        bus_i <= '{a, v, w, !w};
        @(posedge clock_i);
        bus_i <= '0;
        #1 g = rdata_o;
    endtask
    task automatic do_reset(input logic strap);
        @(posedge clock_i);
        detect <= strap;
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
    endtask
    // Polls until the go bit drops; the engine's answer time is random
    task automatic rom_read(input int n);
        delay <= 3'($urandom_range(0, 5));
        acc(A_ROM, 32'h0200_0000, 1'b1);
        g = 32'h0200_0000;
        for (int i = 0; i < 20 && g[25] !== 1'b0; i++) acc(A_ROM, 32'h0, 1'b0);
        chk(g, {8'h0, 8'(n) ^ 8'h5a, 8'h0, PTR});
    endtask
    initial begin
        bus_i = '0;
        rst_n_i = 1'b0;
        detect = 1'b0;
        res = '{default: 32'h0};
        void'($urandom(87085));
        do_reset(1'b0);
        acc(A_ROM, 32'h0, 1'b0);
        chk(g & 32'hff00_ffff, 32'h0);
        acc(A_CTL, 32'h0, 1'b0);
        chk(g & 32'hffff_fffc, 32'h8000_0000);
        do_reset(1'b1);
        for (int i = 0; i < 20 && g[7:0] !== PTR; i++) acc(A_ROM, 32'h0, 1'b0);
        chk(g[7:0], PTR);
        chk({31'h0, pres}, 32'h1);
        repeat (4) begin
            d = $urandom();
            acc(ocsr_pkg::ADDR_RETRY_LIMITS, d, 1'b1);
            acc(ocsr_pkg::ADDR_RETRY_LIMITS, 32'h0, 1'b0);
            chk(g, d & 32'h0000_0fff);
            chk({20'h0, ph_o, rs_o, rq_o}, d & 32'h0000_0fff);
        end
        acc(A_ROM, 32'h8000_0000, 1'b1);
        for (int n = 0; n < 3; n++) rom_read(n);
        acc(A_ROM, 32'h8000_0000, 1'b1);
        acc(A_ROM, 32'h0, 1'b0);
        chk(g, {16'h0058, 8'h0, PTR});
        rom_read(0);
        for (int p = 0; p < 8; p++) begin
            s = p % 4;
            d = $urandom();
            c = (p < 4) ? res[s] : ~res[s];
            acc(ocsr_pkg::ADDR_CSWAP_DATA_LD, d, 1'b1);
            acc(ocsr_pkg::ADDR_CSWAP_CMP_LD, c, 1'b1);
            acc(ocsr_pkg::ADDR_CSWAP_DATA, 32'h0, 1'b0);
            chk(g, d);
            acc(ocsr_pkg::ADDR_CSWAP_COMPARE, 32'h0, 1'b0);
            chk(g, c);
            if (c == res[s]) res[s] = d;
            @(posedge clock_i);
            bus_i <= '{A_CTL, 32'(s), 1'b1, 1'b0};
            acc(A_CTL, 32'h0, 1'b0);
            chk(g, 32'(s));
            acc(A_CTL, 32'h0, 1'b0);
            chk(g, 32'h8000_0000 | 32'(s));
            for (int k = 0; k < 4; k++) chk(res_o[k], res[k]);
        end
        acc(8'h30, $urandom(), 1'b1);
        acc(8'h30, 32'h0, 1'b0);
        chk(g, 32'h0);
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        fails++;
        close_out();
    end
endmodule // ocsr_regs_bench
bind ocsr_regs ocsr_regs_monitor mon (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .eeprom_present_flag_o(eeprom_present_flag_o), .rom_req_o(rom_req_o),
    .rom_ack_i(rom_ack_i), .phys_response_retry_max_o(phys_response_retry_max_o),
    .at_response_retry_max_o(at_response_retry_max_o),
    .at_request_retry_max_o(at_request_retry_max_o), .bus_manager_id_o(bus_manager_id_o));
